//--- tb/acc_bench.sv
// self-checking bench for the analog converter control block
`timescale 1ns/1ps
module acc_bench;
   logic mclk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic pready, pslverr, er, core_start, core_init, core_enable, conversion_irq;
   logic [4:0] core_channel;
   logic [9:0] core_result;
   logic [7:1] trigger_flags = 7'h00;
   logic global_irq_enable = 1'h1, irq_vector_ack = 1'h0;
   logic [7:0] pin_raw = 8'h00, pin_value, pin_buffer_off_bits, d8;
   logic [4:0] tbl [9] = '{5'h07, 5'h10, 5'h17, 5'h18, 5'h1D, 5'h1E, 5'h00, 5'h1F, 5'h03};
   int failures = 0, checks = 0, seed = 13, cyc_n = 0, k;
   always #2 mclk = ~mclk;
   always @(posedge mclk) cyc_n <= cyc_n + 1;
   acc_top dut_u (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .core_start, .core_init, .core_channel, .core_enable,
      .core_result, .trigger_flags, .global_irq_enable, .irq_vector_ack,
      .conversion_irq, .pin_raw, .pin_value, .pin_buffer_off_bits);
   acc_core_model core_u (.mclk, .core_enable, .core_channel, .core_result);
   //////////////////////////////////////////////////////////////////////
   task end_of_test;
      begin
         if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask : end_of_test
   task cmp_val(input logic [31:0] got, input logic [31:0] exp);
      begin
         checks++;
         if (got !== exp)
         begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask : cmp_val
   task cmp_win(input int got, input int lo, input int hi);
      begin
         checks++;
         if (got < lo || got > hi)
         begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, lo);
         end
      end
   endtask : cmp_win
   task hang;
      begin
         failures++;
         end_of_test;
      end
   endtask : hang
   // apb master: hold everything until pready is sampled high
   task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
      int i;
      begin
         @(posedge mclk);
         psel <= 1'h1;
         pwrite <= wr_en;
         paddr <= a;
         pwdata <= d;
         @(posedge mclk);
         penable <= 1'h1;
         for (i = 0; i < 9 && pready !== 1'h1; i++)
            @(posedge mclk);
         if (i == 9)
            hang;
         rv = prdata;
         er = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] exp);
      begin
         apb(1'h0, a, 32'h0);
         cmp_val(rv, exp);
      end
   endtask : rd
   task wait_irq;
      int i;
      begin
         for (i = 0; i < 9000 && conversion_irq !== 1'h1; i++)
            @(posedge mclk);
         if (i == 9000)
            hang;
      end
   endtask : wait_irq
   task watch(input int n, input int exp);
      int i, p;
      begin
         p = 0;
         for (i = 0; i < n; i++)
         begin
            @(posedge mclk);
            p += (core_start === 1'h1);
         end
         cmp_val(32'(p), 32'(exp));
      end
   endtask : watch
   function logic [31:0] res_byte(input logic [4:0] c, input logic lft, input logic hi);
      logic [9:0] r;
      begin
         r = {c, ~c};
         if (lft)
            return hi ? {24'h0, r[9:2]} : {24'h0, r[1:0], 6'h00};
         return hi ? {30'h0, r[9:8]} : {24'h0, r[7:0]};
      end
   endfunction : res_byte
   // one conversion; the flag write of one also clears an old flag
   task conv(input logic [7:0] ctl, input int cyc, input logic [4:0] cn, input logic [4:0] cx);
      int t0, d;
      begin
         d = ctl[2:0] < 3'h2 ? 2 : 1 << ctl[2:0];
         wr(acc_pkg::ADDR_CTRL_STAT, {24'h0, ctl | 8'h50}); // full write
         t0 = cyc_n;
         rd(acc_pkg::ADDR_CTRL_STAT, {24'h0, ctl | 8'h40}); // busy bit
         cmp_val(32'(core_init), 32'(cyc == 25)); // init pass
         wr(acc_pkg::ADDR_INPUT_SEL, {27'h0, cx});
         cmp_val(32'(core_channel), 32'(cn)); // channel held
         wait_irq;
         cmp_win(cyc_n - t0, d * cyc, d * cyc + 4); // length
         rd(acc_pkg::ADDR_CTRL_STAT, {24'h0, ctl | 8'h10}); // end state
         cmp_val(32'(core_channel), 32'(cx)); // channel applied
         rd(acc_pkg::ADDR_RES_LOW, res_byte(cn, 1'h0, 1'h0)); // low first
         rd(acc_pkg::ADDR_RES_HIGH, res_byte(cn, 1'h0, 1'h1)); // high byte
      end
   endtask : conv
   //////////////////////////////////////////////////////////////////////
   initial
   begin
      tbl[8] = 5'($random(seed) & 7);
      repeat (20) @(posedge mclk);
      reset <= 1'h0;
      for (k = 0; k < 6; k++)
         rd(12'(4 * k), 32'h0); // reset zero
      apb(1'h0, 12'h018, 32'h0);
      cmp_val({31'h0, er}, 32'h1); // unmapped refused
      wr(acc_pkg::ADDR_TRIG_CTRL, 32'h7F); // top bit zero
      rd(acc_pkg::ADDR_TRIG_CTRL, 32'h47); // reserved reads zero
      for (k = 0; k < 4; k++)
      begin
         d8 = 8'($random(seed));
         pin_raw <= 8'($random(seed));
         wr(acc_pkg::ADDR_PIN_DIS, {24'h0, d8});
         repeat (4) @(posedge mclk);
         cmp_val(32'(pin_value), 32'(pin_raw & ~d8)); // pin gated
         cmp_val(32'(pin_buffer_off_bits), 32'(d8)); // buffer off
      end
      wr(acc_pkg::ADDR_TRIG_CTRL, 32'h00);
      wr(acc_pkg::ADDR_INPUT_SEL, {27'h0, tbl[0]});
      conv(8'h89, 25, tbl[0], tbl[0]);
      global_irq_enable <= 1'h0;
      repeat (2) @(posedge mclk);
      cmp_val(32'(conversion_irq), 32'h0); // global gate
      global_irq_enable <= 1'h1;
      irq_vector_ack <= 1'h1;
      @(posedge mclk);
      irq_vector_ack <= 1'h0;
      repeat (2) @(posedge mclk);
      cmp_val(32'(conversion_irq), 32'h0); // vector clear
      rd(acc_pkg::ADDR_CTRL_STAT, 32'h89); // flag cleared
      wr(acc_pkg::ADDR_INPUT_SEL, {27'h0, tbl[0]} | 32'h20);
      rd(acc_pkg::ADDR_RES_LOW, res_byte(tbl[0], 1'h1, 1'h0)); // left low
      rd(acc_pkg::ADDR_RES_HIGH, res_byte(tbl[0], 1'h1, 1'h1)); // left high
      wr(acc_pkg::ADDR_INPUT_SEL, {27'h0, tbl[0]});
      for (k = 0; k < 8; k++)
         conv(8'h88 | 8'(k), 13, tbl[k], tbl[k + 1]); // every code
      rd(acc_pkg::ADDR_RES_LOW, res_byte(tbl[7], 1'h0, 1'h0));
      wr(acc_pkg::ADDR_CTRL_STAT, 32'hD9);
      wait_irq;
      rd(acc_pkg::ADDR_RES_HIGH, res_byte(tbl[7], 1'h0, 1'h1)); // update blocked
      wr(acc_pkg::ADDR_CTRL_STAT, 32'hD9);
      wr(acc_pkg::ADDR_CTRL_STAT, 32'h19);
      repeat (60) @(posedge mclk);
      cmp_val(32'(conversion_irq), 32'h0); // abort
      rd(acc_pkg::ADDR_CTRL_STAT, 32'h09); // idle off
      wr(acc_pkg::ADDR_TRIG_CTRL, 32'h03);
      wr(acc_pkg::ADDR_CTRL_STAT, 32'h99);
      trigger_flags[3] <= 1'h1;
      watch(12, 0); // source ignored
      trigger_flags[3] <= 1'h0;
      wr(acc_pkg::ADDR_CTRL_STAT, 32'hB9);
      trigger_flags[3] <= 1'h1;
      watch(12, 1); // flag edge
      wait_irq;
      wr(acc_pkg::ADDR_CTRL_STAT, 32'hB9);
      trigger_flags[3] <= 1'h0;
      trigger_flags[5] <= 1'h1;
      wr(acc_pkg::ADDR_TRIG_CTRL, 32'h05);
      watch(12, 1); // switch edge
      wait_irq;
      wr(acc_pkg::ADDR_TRIG_CTRL, 32'h00);
      watch(12, 0); // no free run event
      wr(acc_pkg::ADDR_CTRL_STAT, 32'hF9);
      watch(70, 3); // free run restart
      end_of_test;
   end
endmodule : acc_bench

//--- tb/acc_core_model.sv
// behavioural conversion core beside the converter control block
`timescale 1ns/1ps
module acc_core_model
(
   // clock
   input wire logic mclk,
   // control from the block
   input wire logic core_enable,
   input wire logic [4:0] core_channel,
   // result to the block
   output logic [9:0] core_result
);
   logic [9:0] junk_q = 10'h155;
   //////////////////////////////////////////////////////////////////////
   // powered off the output wanders, so a stale code cannot pass
   always @(posedge mclk)
   begin
      junk_q <= ~junk_q;
   end
   assign core_result = core_enable ? {core_channel, ~core_channel} : junk_q;
endmodule : acc_core_model

//--- verilog/acc_pkg.sv
// constants for the analog converter control block
package acc_pkg;
   localparam logic [11:0] ADDR_INPUT_SEL = 12'h000;
   localparam logic [11:0] ADDR_CTRL_STAT = 12'h004;
   localparam logic [11:0] ADDR_RES_LOW = 12'h008;
   localparam logic [11:0] ADDR_RES_HIGH = 12'h00C;
   localparam logic [11:0] ADDR_TRIG_CTRL = 12'h010;
   localparam logic [11:0] ADDR_PIN_DIS = 12'h014;
   localparam int BIT_ENABLE = 7;
   localparam int BIT_START = 6;
   localparam int BIT_AUTO = 5;
   localparam int BIT_DONE = 4;
   localparam int BIT_IRQ_EN = 3;
   localparam int BIT_LEFT = 5;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [4:0] FIRST_CYCLES = 5'h19;
   localparam logic [4:0] NORMAL_CYCLES = 5'h0D;
   localparam logic [2:0] TRIG_FREE = 3'h0;
   typedef enum logic [1:0] {ACC_IDLE = 2'b00, ACC_BUSY = 2'b01} acc_state_t;
endpackage : acc_pkg

//--- verilog/acc_top.sv
// register file and sequencer of the analog converter control block
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module acc_top
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // conversion core
   output logic core_start,
   output logic core_init,
   output logic [4:0] core_channel,
   output logic core_enable,
   input wire logic [9:0] core_result,
   // trigger sources, on-chip flags on mclk (index = source code)
   input wire logic [7:1] trigger_flags,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output logic conversion_irq,
   // digital pins
   input wire logic [7:0] pin_raw,
   output logic [7:0] pin_value,
   output logic [7:0] pin_buffer_off_bits
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] input_sel_q;
   logic [7:0] ctrl_q;
   logic [7:0] trig_q;
   logic [7:0] pin_dis_q;
   logic [9:0] result_q;
   logic lock_q;
   logic first_q;
   logic busy_q;
   logic [4:0] chan_q;
   logic [6:0] div_cnt_q;
   logic [4:0] cyc_q;
   logic [4:0] cyc_len_q;
   logic trig_sel_q;
   logic [7:0] p1_q, p2_q, p3_q;
   acc_pkg::acc_state_t state_q;
   logic wr, rd, wr_ctrl, start_req, trig_now, done_ev, div_tick;
   logic [6:0] div_max;
   logic [7:0] res_hi, res_lo, rdata;

   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign wr_ctrl = wr && paddr == acc_pkg::ADDR_CTRL_STAT;
   // a write that enables may also start, so take the enable it carries
   logic en_now;
   assign en_now = wr_ctrl ? pwdata[acc_pkg::BIT_ENABLE] : ctrl_q[acc_pkg::BIT_ENABLE];

   // divisor as terminal count, minus one
   function automatic logic [6:0] div_code(input logic [2:0] c);
      case (c)
         3'h0, 3'h1: div_code = 7'h01;
         3'h2: div_code = 7'h03;
         3'h3: div_code = 7'h07;
         3'h4: div_code = 7'h0F;
         3'h5: div_code = 7'h1F;
         3'h6: div_code = 7'h3F;
         default: div_code = 7'h7F;
      endcase
   endfunction : div_code

   assign div_max = div_code(ctrl_q[2:0]);
   assign div_tick = div_cnt_q == div_max;
   always_ff @(posedge mclk)
   begin
      if (reset || !busy_q)
         div_cnt_q <= 7'h00;
      else
         div_cnt_q <= div_tick ? 7'h00 : div_cnt_q + 7'h01;
   end

   // selected flag, forced low for the free running code
   logic trig_sel;
   logic [7:0] flag_all;
   // code zero has no flag, so a switch to free running never makes an edge
   assign flag_all = {trigger_flags, 1'b0};
   always_comb
   begin
      trig_sel = 1'b0;
      if (trig_q[2:0] != acc_pkg::TRIG_FREE)
         trig_sel = flag_all[trig_q[2:0]];
   end
   always_ff @(posedge mclk)
   begin
      if (reset)
         trig_sel_q <= 1'b0;
      else
         trig_sel_q <= trig_sel;
   end
   // rise after a switch counts too; free run gives none
   assign trig_now = ctrl_q[acc_pkg::BIT_AUTO] && trig_sel && !trig_sel_q;

   assign done_ev = busy_q && div_tick && cyc_q == cyc_len_q - 5'h01;

   // start by write or auto trigger; free running restart is made in the sequencer
   assign start_req = en_now && !busy_q &&
      ((wr_ctrl && pwdata[acc_pkg::BIT_START]) || trig_now);

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_q <= acc_pkg::ACC_IDLE;
         busy_q <= 1'b0;
         cyc_q <= 5'h00;
         cyc_len_q <= acc_pkg::NORMAL_CYCLES;
         first_q <= 1'b1;
         chan_q <= 5'h00;
         core_start <= 1'b0;
         core_init <= 1'b0;
      end
      else
      begin
         core_start <= 1'b0;
         // disable aborts and rearms the init conversion
         if (!en_now)
         begin
            state_q <= acc_pkg::ACC_IDLE;
            busy_q <= 1'b0;
            first_q <= 1'b1;
            core_init <= 1'b0;
         end
         else
         begin
            case (state_q)
               acc_pkg::ACC_IDLE:
               begin
                  if (start_req)
                  begin
                     state_q <= acc_pkg::ACC_BUSY;
                     busy_q <= 1'b1;
                     cyc_q <= 5'h00;
                     cyc_len_q <= first_q ? acc_pkg::FIRST_CYCLES : acc_pkg::NORMAL_CYCLES;
                     core_init <= first_q;
                     first_q <= 1'b0;
                     chan_q <= input_sel_q[4:0];
                     core_start <= 1'b1;
                  end
               end
               acc_pkg::ACC_BUSY:
               begin
                  if (div_tick)
                     cyc_q <= cyc_q + 5'h01;
                  if (done_ev)
                  begin
                     cyc_q <= 5'h00;
                     core_init <= 1'b0;
                     chan_q <= input_sel_q[4:0];
                     if (ctrl_q[acc_pkg::BIT_AUTO] && trig_q[2:0] == acc_pkg::TRIG_FREE)
                     begin
                        cyc_len_q <= acc_pkg::NORMAL_CYCLES;
                        core_start <= 1'b1;
                     end
                     else
                     begin
                        state_q <= acc_pkg::ACC_IDLE;
                        busy_q <= 1'b0;
                     end
                  end
               end
               default:
               begin
                  state_q <= acc_pkg::ACC_IDLE;
                  busy_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // channel code passed to core; unused codes left to the core
   assign core_channel = chan_q;
   assign core_enable = ctrl_q[acc_pkg::BIT_ENABLE];

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         input_sel_q <= acc_pkg::RESET_BYTE;
         trig_q <= acc_pkg::RESET_BYTE;
         pin_dis_q <= acc_pkg::RESET_BYTE;
      end
      else if (wr)
      begin
         if (paddr == acc_pkg::ADDR_INPUT_SEL)
            input_sel_q <= pwdata[7:0];
         if (paddr == acc_pkg::ADDR_TRIG_CTRL)
            trig_q <= {1'b0, pwdata[6], 3'h0, pwdata[2:0]};
         if (paddr == acc_pkg::ADDR_PIN_DIS)
            pin_dis_q <= pwdata[7:0];
      end
   end

   function automatic logic core_start_next();
      core_start_next = ctrl_q[acc_pkg::BIT_ENABLE] && ctrl_q[acc_pkg::BIT_AUTO] &&
         trig_q[2:0] == acc_pkg::TRIG_FREE;
   endfunction : core_start_next

   always_ff @(posedge mclk)
   begin
      if (reset)
         ctrl_q <= acc_pkg::RESET_BYTE;
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_q[7] <= pwdata[7];
            ctrl_q[5] <= pwdata[5];
            ctrl_q[3:0] <= pwdata[3:0];
         end
         // start bit mirrors busy, zero writes ignored
         ctrl_q[acc_pkg::BIT_START] <= busy_q ? !done_ev || core_start_next() : start_req;
         // set wins over vector or write-one clear
         if (done_ev)
            ctrl_q[acc_pkg::BIT_DONE] <= 1'b1;
         else if (irq_vector_ack || (wr_ctrl && pwdata[acc_pkg::BIT_DONE]))
            ctrl_q[acc_pkg::BIT_DONE] <= 1'b0;
      end
   end

   // low byte read locks, high byte read unlocks
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         result_q <= 10'h000;
         lock_q <= 1'b0;
      end
      else
      begin
         if (rd && paddr == acc_pkg::ADDR_RES_LOW)
            lock_q <= 1'b1;
         else if (rd && paddr == acc_pkg::ADDR_RES_HIGH)
            lock_q <= 1'b0;
         // result code kept as delivered, signed or unsigned
         if (done_ev && !lock_q)
            result_q <= core_result;
      end
   end

   // alignment; applied live at read time
   assign res_hi = input_sel_q[acc_pkg::BIT_LEFT] ? result_q[9:2] : {6'h00, result_q[9:8]};
   assign res_lo = input_sel_q[acc_pkg::BIT_LEFT] ? {result_q[1:0], 6'h00} : result_q[7:0];

   always_comb
   begin
      case (paddr)
         acc_pkg::ADDR_INPUT_SEL: rdata = input_sel_q;
         acc_pkg::ADDR_CTRL_STAT: rdata = ctrl_q;
         acc_pkg::ADDR_RES_LOW: rdata = res_lo;
         acc_pkg::ADDR_RES_HIGH: rdata = res_hi;
         acc_pkg::ADDR_TRIG_CTRL: rdata = trig_q;
         acc_pkg::ADDR_PIN_DIS: rdata = pin_dis_q;
         default: rdata = 8'h00;
      endcase
   end

   // zero wait state; unmapped reads zero with pslverr
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > acc_pkg::ADDR_PIN_DIS || paddr[1:0] != 2'h0);
         prdata <= {24'h000000, rdata};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins: three-stage sync, change taken when stages two and three agree
   logic [7:0] pin_stable_q;
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         p1_q <= 8'h00;
         p2_q <= 8'h00;
         p3_q <= 8'h00;
         pin_stable_q <= 8'h00;
      end
      else
      begin
         p1_q <= pin_raw;
         p2_q <= p1_q;
         p3_q <= p2_q;
         pin_stable_q <= (p2_q & p3_q) | (pin_stable_q & (p2_q | p3_q));
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         pin_value <= 8'h00;
         pin_buffer_off_bits <= 8'h00;
         conversion_irq <= 1'b0;
      end
      else
      begin
         pin_value <= pin_stable_q & ~pin_dis_q;
         pin_buffer_off_bits <= pin_dis_q;
         conversion_irq <= ctrl_q[acc_pkg::BIT_DONE] & ctrl_q[acc_pkg::BIT_IRQ_EN] &
            global_irq_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flag, start bit, abort, lock, irq, pin, channel, trigger and restart checks
   a_done_sets_flag: assert property (@(posedge mclk) disable iff (reset)
      done_ev |=> ctrl_q[acc_pkg::BIT_DONE]) else $error("done flag not set");
   a_start_tracks_busy: assert property (@(posedge mclk) disable iff (reset)
      busy_q |-> ctrl_q[acc_pkg::BIT_START]) else $error("start bit low while busy");
   a_disable_aborts: assert property (@(posedge mclk) disable iff (reset)
      !en_now |=> !busy_q) else $error("busy while disabled");
   a_lock_holds_result: assert property (@(posedge mclk) disable iff (reset)
      lock_q |=> $stable(result_q)) else $error("result changed while locked");
   a_irq_gating: assert property (@(posedge mclk) disable iff (reset)
      conversion_irq |-> $past(ctrl_q[acc_pkg::BIT_DONE] & ctrl_q[acc_pkg::BIT_IRQ_EN] &
      global_irq_enable)) else $error("irq without cause");
   a_pin_masked: assert property (@(posedge mclk) disable iff (reset)
      |$past(pin_dis_q) |-> (pin_value & $past(pin_dis_q)) == 8'h00)
      else $error("disabled pin not zero");
   a_channel_stable: assert property (@(posedge mclk) disable iff (reset)
      busy_q && $past(busy_q) && !$past(done_ev) |-> $stable(chan_q))
      else $error("channel moved");
   a_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
      trig_q[7] == 1'b0) else $error("reserved bit set");
   a_first_long: assert property (@(posedge mclk) disable iff (reset)
      core_start && core_init |=> cyc_len_q == acc_pkg::FIRST_CYCLES)
      else $error("first conversion not long");
   a_end_together: assert property (@(posedge mclk) disable iff (reset)
      done_ev && !core_start_next() |=> !busy_q && !ctrl_q[acc_pkg::BIT_START] &&
      ctrl_q[acc_pkg::BIT_DONE]) else $error("end of conversion not aligned");
   a_result_update: assert property (@(posedge mclk) disable iff (reset)
      done_ev && !lock_q |=> result_q == $past(core_result))
      else $error("result not updated");
   a_trigger_starts: assert property (@(posedge mclk) disable iff (reset)
      trig_now && en_now && !busy_q |=> core_start && busy_q)
      else $error("trigger edge ignored");
   a_free_restart: assert property (@(posedge mclk) disable iff (reset)
      done_ev && en_now && core_start_next() |=> core_start && busy_q)
      else $error("free running did not restart");
endmodule : acc_top
